// File: rtl/dorc_consts.svh
// constants for the door driver output control register bank
`ifndef DORC_CONSTS_SVH
`define DORC_CONSTS_SVH

`define DORC_ADDR_BRIDGE 6'h00
`define DORC_ADDR_LAMP 6'h01
`define DORC_MASK_BRIDGE 16'hfff1
`define DORC_MASK_LAMP 16'hfffe
`define DORC_RESET_WORD 16'h0000
`define DORC_MODE_BIT 0
`define DORC_BRIDGE_LSB 4
`define DORC_BRIDGE_MSB 15
`define DORC_PWM_B_BRIDGE 4
`define DORC_L7_HI 15
`define DORC_L7_LO 14
`define DORC_L8_HI 13
`define DORC_L8_LO 12
`define DORC_L9 11
`define DORC_L10 10
`define DORC_L11 9
`define DORC_PULLDOWN_BIT 8
`define DORC_DAC_HI 7
`define DORC_DAC_LO 2
`define DORC_MIRROR_EN_BIT 1
`define DORC_DAC_ZERO 6'h00
`define DORC_DAC_CLAMP 6'h33
`define DORC_CODE_BULB 2'b10
`define DORC_SETTLE_US 100
`define DORC_CLK_MHZ 40
`define DORC_SETTLE_CYCLES (`DORC_SETTLE_US * `DORC_CLK_MHZ)
`define DORC_TIMER_W 13

`endif

// File: rtl/dorc_pkg.sv
// types for the door driver output control register bank
package dorc_pkg;
  typedef enum logic [1:0]
  {
    DORC_STANDBY = 2'b00,
    DORC_SETTLING = 2'b01,
    DORC_ACTIVE = 2'b10
  } dorc_state_type;
endpackage

// File: rtl/dorc_gate_if.sv
// interface carrying enables and pwm sources into the output gating
`timescale 1ns/10ps
interface dorc_gate_if;
  logic run;
  logic [5:0] bridge_high;
  logic [5:0] bridge_low;
  logic [5:0] bridge_pwm_sel;
  logic [4:0] lamp_on;
  logic [4:0] lamp_pwm_sel;
  logic [4:0] lamp_pwm_src;
  logic pwm_a;
  logic pwm_b;
  modport ctrl (output run, bridge_high, bridge_low, bridge_pwm_sel, lamp_on, lamp_pwm_sel,
    lamp_pwm_src, pwm_a, pwm_b);
  modport gate (input run, bridge_high, bridge_low, bridge_pwm_sel, lamp_on, lamp_pwm_sel,
    lamp_pwm_src, pwm_a, pwm_b);
endinterface

// File: rtl/dorc_output_gate.sv
// output gating of bridge and lamp drivers by enable, pwm and readiness
`timescale 1ns/10ps
`include "dorc_consts.svh"
module dorc_output_gate
  import dorc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  dorc_gate_if.gate g,
  output logic [5:0] high_on,
  output logic [5:0] low_on,
  output logic [4:0] lamp_drive
);
  logic [5:0] next_high_on;
  logic [5:0] next_low_on;
  logic [4:0] next_lamp_drive;
  logic [5:0] gate_ok;

  // bridge 5 follows pwm_b, all others pwm_a
  function automatic logic bridge_pwm(input int idx, input logic a, input logic b);
    return (idx == `DORC_PWM_B_BRIDGE) ? b : a;
  endfunction

  always_comb
  begin
    next_high_on = 6'h00;
    next_low_on = 6'h00;
    next_lamp_drive = 5'h00;
    gate_ok = 6'h00;
    for (int i = 0; i < 6; i++)
    begin
      gate_ok[i] = g.run &&
        (!g.bridge_pwm_sel[i] || bridge_pwm(i, g.pwm_a, g.pwm_b));
      // 11 is high impedance, so the two sides never conduct together
      next_high_on[i] = gate_ok[i] && g.bridge_high[i] && !g.bridge_low[i];
      next_low_on[i] = gate_ok[i] && g.bridge_low[i] && !g.bridge_high[i];
    end
    for (int j = 0; j < 5; j++)
    begin
      next_lamp_drive[j] = g.run && g.lamp_on[j] &&
        (!g.lamp_pwm_sel[j] || g.lamp_pwm_src[j]);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      high_on <= 6'h00;
      low_on <= 6'h00;
      lamp_drive <= 5'h00;
    end
    else
    begin
      high_on <= next_high_on;
      low_on <= next_low_on;
      lamp_drive <= next_lamp_drive;
    end
  end
endmodule

// File: rtl/dorc_control_regs.sv
// control and status register bank of the door load driver
//
// Operation
// - supply/overcurrent flag ORs all those faults
// - underload flag ORs underloads, maskable, first-bridge mask
// - standby-to-active sets not-ready, timer blocks outputs
// - bridge with pwm select follows its pwm pin
// - writing mode bit one enters active mode
// - clearing mode bit clears registers, outputs off
// - lamp codes 01 led, 10 bulb; others single-bit
// - lamp with pwm select follows selected source
// - pulldown only when enabled and dac zero
// - pulldown with pwm select follows pwm_a
// - dac field sets reference, clamped without full scale
// - reference is code times 1.5/64, full scale unclamped
// - mirror enable drives pass transistor output
// - mirror enable forces lamp channel ten on
`timescale 1ns/10ps
`include "dorc_consts.svh"
module dorc_control_regs
  import dorc_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic WR_EN,
  input wire logic RD_EN,
  input wire logic [5:0] ADDR,
  input wire logic [15:0] WR_DATA,
  output logic [15:0] RD_DATA,
  input wire logic [2:0] SUPPLY_FAULT,
  input wire logic [10:0] OVERCURRENT,
  input wire logic [5:0] BRIDGE_HIGH_UNDERLOAD,
  input wire logic [5:0] BRIDGE_LOW_UNDERLOAD,
  input wire logic [4:0] LAMP_UNDERLOAD,
  input wire logic UNDERLOAD_MASK,
  input wire logic FIRST_BRIDGE_UNDERLOAD_MASK,
  input wire logic [5:0] BRIDGE_PWM_SELECT,
  input wire logic [4:0] LAMP_PWM_SELECT,
  input wire logic [1:0] LAMP_INTERNAL_SELECT,
  input wire logic PULLDOWN_PWM_SELECT,
  input wire logic FULL_SCALE_SELECT,
  input wire logic INTERNAL_PWM,
  input wire logic PWM_INPUT_A,
  input wire logic PWM_INPUT_B,
  output logic SUPPLY_OR_OVERCURRENT_FLAG,
  output logic UNDERLOAD_FLAG,
  output logic NOT_READY_FLAG,
  output logic ACTIVE_MODE,
  output logic [5:0] HIGH_SIDE_ON,
  output logic [5:0] LOW_SIDE_ON,
  output logic [4:0] LAMP_ON,
  output logic LAMP7_BULB_MODE,
  output logic LAMP8_BULB_MODE,
  output logic MIRROR_PULLDOWN_ON,
  output logic PASS_TRANSISTOR_DRIVE,
  output logic [5:0] MIRROR_REFERENCE_CODE
);
  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] pwm_a_meta;
  logic [1:0] pwm_b_meta;
  logic pwm_a_sync;
  logic pwm_b_sync;
  logic [1:0] next_pwm_a_meta;
  logic [1:0] next_pwm_b_meta;

  always_comb
  begin
    next_pwm_a_meta = {pwm_a_meta[0], PWM_INPUT_A};
    next_pwm_b_meta = {pwm_b_meta[0], PWM_INPUT_B};
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RSTN)
    begin
      pwm_a_meta <= 2'h0;
      pwm_b_meta <= 2'h0;
    end
    else
    begin
      pwm_a_meta <= next_pwm_a_meta;
      pwm_b_meta <= next_pwm_b_meta;
    end
  end

  // only the second stage is read
  // config selects share this clock, so only the two pins are synchronised
  assign pwm_a_sync = pwm_a_meta[1];
  assign pwm_b_sync = pwm_b_meta[1];

  // ----------------------------------------------------------------
  // registers and mode sequencing
  // ----------------------------------------------------------------
  logic [15:0] bridge_reg;
  logic [15:0] lamp_reg;
  logic [15:0] next_bridge_reg;
  logic [15:0] next_lamp_reg;
  dorc_state_type state;
  dorc_state_type next_state;
  logic [`DORC_TIMER_W-1:0] timer;
  logic [`DORC_TIMER_W-1:0] next_timer;
  logic mode_write;
  logic mode_value;

  localparam logic [`DORC_TIMER_W-1:0] SETTLE_LAST =
    `DORC_TIMER_W'(`DORC_SETTLE_CYCLES - 1);

  // one strobe decode shared by the write, mode and read paths
  function automatic logic addr_hit(input logic en, input logic [5:0] a,
    input logic [5:0] target);
    return en && (a == target);
  endfunction

  assign mode_write = addr_hit(WR_EN, ADDR, `DORC_ADDR_BRIDGE);
  assign mode_value = WR_DATA[`DORC_MODE_BIT];

  always_comb
  begin
    next_bridge_reg = bridge_reg;
    next_lamp_reg = lamp_reg;
    next_state = state;
    next_timer = timer;
    if (mode_write)
      next_bridge_reg = WR_DATA & `DORC_MASK_BRIDGE;
    if (addr_hit(WR_EN, ADDR, `DORC_ADDR_LAMP))
      next_lamp_reg = WR_DATA & `DORC_MASK_LAMP;
    unique case (state)
      DORC_STANDBY:
      begin
        if (mode_write && mode_value)
        begin
          next_state = DORC_SETTLING;
          next_timer = `DORC_TIMER_W'(0);
        end
        else
        begin
          // standby keeps every field at zero except a write that sets the mode bit
          next_bridge_reg = `DORC_RESET_WORD;
          next_lamp_reg = `DORC_RESET_WORD;
        end
      end
      DORC_SETTLING:
      begin
        if (timer == SETTLE_LAST)
          next_state = DORC_ACTIVE;
        else
          next_timer = timer + `DORC_TIMER_W'(1);
      end
      DORC_ACTIVE:
      begin
      end
    endcase
    if (state != DORC_STANDBY && mode_write && !mode_value)
    begin
      // the host must wait the settling delay before setting mode again
      next_state = DORC_STANDBY;
      next_bridge_reg = `DORC_RESET_WORD;
      next_lamp_reg = `DORC_RESET_WORD;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RSTN)
    begin
      bridge_reg <= `DORC_RESET_WORD;
      lamp_reg <= `DORC_RESET_WORD;
      state <= DORC_STANDBY;
      timer <= `DORC_TIMER_W'(0);
    end
    else
    begin
      bridge_reg <= next_bridge_reg;
      lamp_reg <= next_lamp_reg;
      state <= next_state;
      timer <= next_timer;
    end
  end

  // ----------------------------------------------------------------
  // field decode and gating
  // ----------------------------------------------------------------
  dorc_gate_if gif();
  logic [5:0] dac_code;
  logic mirror_en;
  logic [1:0] lamp7_code;
  logic [1:0] lamp8_code;

  assign dac_code = lamp_reg[`DORC_DAC_HI:`DORC_DAC_LO];
  assign mirror_en = lamp_reg[`DORC_MIRROR_EN_BIT];
  assign lamp7_code = lamp_reg[`DORC_L7_HI:`DORC_L7_LO];
  assign lamp8_code = lamp_reg[`DORC_L8_HI:`DORC_L8_LO];

  // a lamp code drives only for 01 and 10
  function automatic logic code_on(input logic [1:0] code);
    return code[1] ^ code[0];
  endfunction

  // code 10 selects the high-current bulb drive
  function automatic logic is_bulb(input logic [1:0] code);
    return code == `DORC_CODE_BULB;
  endfunction

  // outputs trail the state by the one gating register
  assign gif.run = (state == DORC_ACTIVE);
  assign gif.pwm_a = pwm_a_sync;
  assign gif.pwm_b = pwm_b_sync;
  assign gif.bridge_pwm_sel = BRIDGE_PWM_SELECT;
  assign gif.lamp_pwm_sel = LAMP_PWM_SELECT;
  always_comb
  begin
    for (int i = 0; i < 6; i++)
    begin
      gif.bridge_high[i] = bridge_reg[`DORC_BRIDGE_MSB - 2 * i];
      gif.bridge_low[i] = bridge_reg[`DORC_BRIDGE_MSB - 1 - 2 * i];
    end
  end
  assign gif.lamp_on = {lamp_reg[`DORC_L11], lamp_reg[`DORC_L10] | mirror_en,
    lamp_reg[`DORC_L9], code_on(lamp8_code), code_on(lamp7_code)};
  // lamps 7 and 9 use pwm_a, 8 and 10 pwm_b, 11 pwm_a; 7 and 8 may take the internal unit
  assign gif.lamp_pwm_src = {pwm_a_sync, pwm_b_sync, pwm_a_sync,
    LAMP_INTERNAL_SELECT[1] ? INTERNAL_PWM : pwm_b_sync,
    LAMP_INTERNAL_SELECT[0] ? INTERNAL_PWM : pwm_a_sync};

  dorc_output_gate u_gate
  (
    .clk(REF_CLK),
    .rst_n(RSTN),
    .g(gif),
    .high_on(HIGH_SIDE_ON),
    .low_on(LOW_SIDE_ON),
    .lamp_drive(LAMP_ON)
  );

  // ----------------------------------------------------------------
  // status, mirror and read-back
  // ----------------------------------------------------------------
  logic next_supply_flag;
  logic next_underload_flag;
  logic next_pulldown;
  logic [5:0] next_ref_code;
  logic [15:0] next_rd_data;
  logic [5:0] bridge_underload_high;
  logic [5:0] bridge_underload_low;

  always_comb
  begin
    next_supply_flag = |SUPPLY_FAULT || |OVERCURRENT;
    bridge_underload_high = BRIDGE_HIGH_UNDERLOAD;
    bridge_underload_low = BRIDGE_LOW_UNDERLOAD;
    if (FIRST_BRIDGE_UNDERLOAD_MASK)
    begin
      bridge_underload_high[0] = 1'b0;
      bridge_underload_low[0] = 1'b0;
    end
    next_underload_flag = !UNDERLOAD_MASK &&
      (|bridge_underload_high || |bridge_underload_low || |LAMP_UNDERLOAD);
    next_pulldown = gif.run && lamp_reg[`DORC_PULLDOWN_BIT] && dac_code == `DORC_DAC_ZERO &&
      (!PULLDOWN_PWM_SELECT || pwm_a_sync);
    // analog reference is code*1.5/64; code 51 is the 1.2 V step
    next_ref_code = (!FULL_SCALE_SELECT && dac_code > `DORC_DAC_CLAMP) ?
      `DORC_DAC_CLAMP : dac_code;
    next_rd_data = `DORC_RESET_WORD;
    if (addr_hit(RD_EN, ADDR, `DORC_ADDR_BRIDGE))
      next_rd_data = bridge_reg;
    else if (addr_hit(RD_EN, ADDR, `DORC_ADDR_LAMP))
      next_rd_data = lamp_reg;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RSTN)
    begin
      SUPPLY_OR_OVERCURRENT_FLAG <= 1'b0;
      UNDERLOAD_FLAG <= 1'b0;
      NOT_READY_FLAG <= 1'b0;
      ACTIVE_MODE <= 1'b0;
      LAMP7_BULB_MODE <= 1'b0;
      LAMP8_BULB_MODE <= 1'b0;
      MIRROR_PULLDOWN_ON <= 1'b0;
      PASS_TRANSISTOR_DRIVE <= 1'b0;
      MIRROR_REFERENCE_CODE <= 6'h00;
      RD_DATA <= 16'h0000;
    end
    else
    begin
      SUPPLY_OR_OVERCURRENT_FLAG <= next_supply_flag;
      UNDERLOAD_FLAG <= next_underload_flag;
      NOT_READY_FLAG <= (next_state == DORC_SETTLING);
      ACTIVE_MODE <= (next_state != DORC_STANDBY);
      LAMP7_BULB_MODE <= is_bulb(next_lamp_reg[`DORC_L7_HI:`DORC_L7_LO]);
      LAMP8_BULB_MODE <= is_bulb(next_lamp_reg[`DORC_L8_HI:`DORC_L8_LO]);
      MIRROR_PULLDOWN_ON <= next_pulldown;
      PASS_TRANSISTOR_DRIVE <= mirror_en && gif.run;
      MIRROR_REFERENCE_CODE <= next_ref_code;
      RD_DATA <= next_rd_data;
    end
  end
endmodule

// File: testbench/dorc_monitor.sv
// assertion checker for the door driver control register bank
`timescale 1ns/10ps
module dorc_monitor
(
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic RD_EN,
  input wire logic [5:0] ADDR,
  input wire logic [15:0] RD_DATA,
  input wire logic [2:0] SUPPLY_FAULT,
  input wire logic [10:0] OVERCURRENT,
  input wire logic UNDERLOAD_MASK,
  input wire logic FULL_SCALE_SELECT,
  input wire logic SUPPLY_OR_OVERCURRENT_FLAG,
  input wire logic UNDERLOAD_FLAG,
  input wire logic NOT_READY_FLAG,
  input wire logic ACTIVE_MODE,
  input wire logic [5:0] HIGH_SIDE_ON,
  input wire logic [5:0] LOW_SIDE_ON,
  input wire logic [4:0] LAMP_ON,
  input wire logic MIRROR_PULLDOWN_ON,
  input wire logic [5:0] MIRROR_REFERENCE_CODE
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);
  a_fault_or: assert property (
    1 |=> SUPPLY_OR_OVERCURRENT_FLAG == $past(|{SUPPLY_FAULT, OVERCURRENT}))
    else $error("fault flag wrong");
  a_underload_masked: assert property (UNDERLOAD_MASK |=> !UNDERLOAD_FLAG)
    else $error("underload not masked");
  a_bridge_excl: assert property ((HIGH_SIDE_ON & LOW_SIDE_ON) == 6'h00)
    else $error("both bridge sides on");
  a_settle_start: assert property ($rose(ACTIVE_MODE) |-> NOT_READY_FLAG)
    else $error("no settling on activation");
  a_settle_hold: assert property ($rose(NOT_READY_FLAG) |=> NOT_READY_FLAG [*8])
    else $error("settling too short");
  a_ready_gate: assert property (
    NOT_READY_FLAG |-> {HIGH_SIDE_ON, LOW_SIDE_ON, LAMP_ON} == 17'h0)
    else $error("output on while not ready");
  a_standby_off: assert property (
    !ACTIVE_MODE |=> {HIGH_SIDE_ON, LOW_SIDE_ON, LAMP_ON} == 17'h0)
    else $error("output on in standby");
  a_dac_clamp: assert property (
    !$past(FULL_SCALE_SELECT) |-> MIRROR_REFERENCE_CODE <= 6'h33)
    else $error("reference not clamped");
  a_pulldown_dac: assert property (
    MIRROR_PULLDOWN_ON |-> MIRROR_REFERENCE_CODE == 6'h00)
    else $error("pulldown with dac set");
  a_read_unused: assert property (
    RD_EN && ADDR == 6'h00 |=> RD_DATA[3:1] == 3'h0)
    else $error("unused bits read set");
  c_ready: cover property ($fell(NOT_READY_FLAG));
  c_pulldown: cover property (MIRROR_PULLDOWN_ON);
  c_standby: cover property ($fell(ACTIVE_MODE));
endmodule

bind dorc_control_regs dorc_monitor i_dorc_monitor (.REF_CLK, .RSTN, .RD_EN, .ADDR, .RD_DATA,
  .SUPPLY_FAULT, .OVERCURRENT, .UNDERLOAD_MASK, .FULL_SCALE_SELECT, .SUPPLY_OR_OVERCURRENT_FLAG,
  .UNDERLOAD_FLAG, .NOT_READY_FLAG, .ACTIVE_MODE, .HIGH_SIDE_ON, .LOW_SIDE_ON, .LAMP_ON,
  .MIRROR_PULLDOWN_ON, .MIRROR_REFERENCE_CODE);

// File: testbench/dorc_host_model.sv
// host model that issues register writes and reads to the bank
`timescale 1ns/10ps
`include "dorc_consts.svh"
module dorc_host_model
(
  input wire logic clk,
  input wire logic [15:0] rd_data,
  output logic wr_en = 1'b0,
  output logic rd_en = 1'b0,
  output logic [5:0] addr = 6'h00,
  output logic [15:0] wr_data = 16'h0000
);
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'b0;
    wr_data <= ~d;
    // a fresh activation too soon after standby would be illegal
    if (a == `DORC_ADDR_BRIDGE && !d[`DORC_MODE_BIT])
      repeat (`DORC_SETTLE_CYCLES) @(posedge clk);
  endtask
  task automatic rd(input logic [5:0] a, output logic [15:0] d);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    d = rd_data;
  endtask
endmodule

// File: testbench/dorc_control_regs_tb.sv
// self-checking bench for the door driver control register bank
`timescale 1ns/10ps
module dorc_control_regs_tb;
  import dorc_pkg::*;
  logic REF_CLK = 1'b0, RSTN = 1'b0, WR_EN, RD_EN, INTERNAL_PWM = 1'b0;
  logic PWM_INPUT_A = 1'b0, PWM_INPUT_B = 1'b0, UNDERLOAD_MASK = 1'b0;
  logic FIRST_BRIDGE_UNDERLOAD_MASK = 1'b0, PULLDOWN_PWM_SELECT = 1'b0, FULL_SCALE_SELECT = 1'b0;
  logic [2:0] SUPPLY_FAULT = 3'h0;
  logic [10:0] OVERCURRENT = 11'h000;
  logic [5:0] BRIDGE_HIGH_UNDERLOAD = 6'h00, BRIDGE_LOW_UNDERLOAD = 6'h00;
  logic [5:0] BRIDGE_PWM_SELECT = 6'h00, ADDR, HIGH_SIDE_ON, LOW_SIDE_ON, MIRROR_REFERENCE_CODE;
  logic [4:0] LAMP_UNDERLOAD = 5'h00, LAMP_PWM_SELECT = 5'h00, LAMP_ON;
  logic [1:0] LAMP_INTERNAL_SELECT = 2'h0;
  logic [15:0] WR_DATA, RD_DATA;
  logic SUPPLY_OR_OVERCURRENT_FLAG, UNDERLOAD_FLAG, NOT_READY_FLAG, ACTIVE_MODE;
  logic LAMP7_BULB_MODE, LAMP8_BULB_MODE, MIRROR_PULLDOWN_ON, PASS_TRANSISTOR_DRIVE;
  int n_mismatch = 0, checks_done = 0;
  wire [16:0] outs = {HIGH_SIDE_ON, LOW_SIDE_ON, LAMP_ON};

  dorc_control_regs i_dorc_control_regs (.REF_CLK, .RSTN, .WR_EN, .RD_EN, .ADDR, .WR_DATA,
    .RD_DATA, .SUPPLY_FAULT, .OVERCURRENT, .BRIDGE_HIGH_UNDERLOAD, .BRIDGE_LOW_UNDERLOAD,
    .LAMP_UNDERLOAD, .UNDERLOAD_MASK, .FIRST_BRIDGE_UNDERLOAD_MASK, .BRIDGE_PWM_SELECT,
    .LAMP_PWM_SELECT, .LAMP_INTERNAL_SELECT, .PULLDOWN_PWM_SELECT, .FULL_SCALE_SELECT,
    .INTERNAL_PWM, .PWM_INPUT_A, .PWM_INPUT_B, .SUPPLY_OR_OVERCURRENT_FLAG, .UNDERLOAD_FLAG,
    .NOT_READY_FLAG, .ACTIVE_MODE, .HIGH_SIDE_ON, .LOW_SIDE_ON, .LAMP_ON, .LAMP7_BULB_MODE,
    .LAMP8_BULB_MODE, .MIRROR_PULLDOWN_ON, .PASS_TRANSISTOR_DRIVE, .MIRROR_REFERENCE_CODE);
  dorc_host_model i_dorc_host_model (.clk(REF_CLK), .rd_data(RD_DATA), .wr_en(WR_EN),
    .rd_en(RD_EN), .addr(ADDR), .wr_data(WR_DATA));

  always #12.5 REF_CLK = ~REF_CLK;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge REF_CLK);
    #1;
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    i_dorc_host_model.wr(a, d);
  endtask
  task automatic rdc(input logic [5:0] a, input logic [15:0] exp);
    logic [15:0] v;
    i_dorc_host_model.rd(a, v);
    chk(v, exp);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ----------------
  // scenarios
  // ----------------
  task automatic t_idle;
    rdc(6'h00, 16'h0000);
    // standby drops every write that does not set the mode bit
    wr(6'h01, 16'hffff);
    rdc(6'h01, 16'h0000);
    rdc(6'h3f, 16'h0000);
  endtask
  task automatic t_flags;
    for (int i = 0; i < 14; i++)
    begin
      @(posedge REF_CLK);
      {SUPPLY_FAULT, OVERCURRENT} <= 14'h0001 << i;
      cyc(2);
      chk(SUPPLY_OR_OVERCURRENT_FLAG, 1'b1);
    end
    @(posedge REF_CLK);
    {SUPPLY_FAULT, OVERCURRENT} <= 14'h0000;
    BRIDGE_LOW_UNDERLOAD <= 6'h01;
    cyc(2);
    chk({SUPPLY_OR_OVERCURRENT_FLAG, UNDERLOAD_FLAG}, 2'b01);
    for (int i = 0; i < 3; i++)
    begin
      @(posedge REF_CLK);
      FIRST_BRIDGE_UNDERLOAD_MASK <= 1'b1;
      LAMP_UNDERLOAD <= {i > 0, 4'h0};
      UNDERLOAD_MASK <= (i == 2);
      cyc(2);
      chk(UNDERLOAD_FLAG, i == 1);
    end
  endtask
  task automatic t_activate;
    int n;
    n = 0;
    wr(6'h00, 16'h8001);
    cyc(1);
    chk({ACTIVE_MODE, NOT_READY_FLAG, outs}, {2'b11, 17'h0});
    while (NOT_READY_FLAG === 1'b1 && n < 5000)
    begin
      cyc(1);
      n++;
    end
    chk(n > 3990 && n < 4010, 1'b1);
    cyc(2);
    chk(outs, {6'h01, 11'h0});
  endtask
  task automatic t_bridge;
    wr(6'h00, 16'h9c9f);
    rdc(6'h00, 16'h9c91);
    chk({HIGH_SIDE_ON, LOW_SIDE_ON}, 12'h462);
    @(posedge REF_CLK);
    BRIDGE_PWM_SELECT <= 6'h11;
    PWM_INPUT_B <= 1'b1;
    cyc(5);
    chk(HIGH_SIDE_ON, 6'h10);
    @(posedge REF_CLK);
    PWM_INPUT_A <= 1'b1;
    PWM_INPUT_B <= 1'b0;
    cyc(5);
    chk(HIGH_SIDE_ON, 6'h01);
  endtask
  task automatic t_lamp;
    wr(6'h01, 16'h6a00);
    cyc(2);
    chk({LAMP_ON, LAMP7_BULB_MODE, LAMP8_BULB_MODE}, 7'h5d);
    wr(6'h01, 16'hf000);
    cyc(2);
    chk({LAMP_ON, LAMP7_BULB_MODE, LAMP8_BULB_MODE}, 7'h00);
    @(posedge REF_CLK);
    LAMP_PWM_SELECT <= 5'h01;
    LAMP_INTERNAL_SELECT <= 2'b01;
    wr(6'h01, 16'h4000);
    cyc(2);
    chk(LAMP_ON, 5'h00);
    @(posedge REF_CLK);
    INTERNAL_PWM <= 1'b1;
    cyc(2);
    chk(LAMP_ON, 5'h01);
  endtask
  task automatic t_mirror;
    @(posedge REF_CLK);
    LAMP_PWM_SELECT <= 5'h00;
    wr(6'h01, 16'h0002);
    cyc(2);
    chk({PASS_TRANSISTOR_DRIVE, LAMP_ON}, 6'h28);
    @(posedge REF_CLK);
    PULLDOWN_PWM_SELECT <= 1'b1;
    PWM_INPUT_A <= 1'b0;
    wr(6'h01, 16'h0100);
    cyc(5);
    chk(MIRROR_PULLDOWN_ON, 1'b0);
    @(posedge REF_CLK);
    PWM_INPUT_A <= 1'b1;
    cyc(5);
    chk(MIRROR_PULLDOWN_ON, 1'b1);
    wr(6'h01, 16'h01fc);
    cyc(2);
    chk({MIRROR_PULLDOWN_ON, MIRROR_REFERENCE_CODE}, 7'h33);
    @(posedge REF_CLK);
    FULL_SCALE_SELECT <= 1'b1;
    cyc(2);
    chk(MIRROR_REFERENCE_CODE, 6'h3f);
  endtask
  task automatic t_standby;
    wr(6'h00, 16'h0000);
    cyc(1);
    chk({ACTIVE_MODE, outs, PASS_TRANSISTOR_DRIVE, MIRROR_REFERENCE_CODE}, 25'h0);
    rdc(6'h01, 16'h0000);
  endtask

  initial
  begin
    repeat (20000) @(posedge REF_CLK);
    n_mismatch++;
    report_and_stop;
  end
  initial
  begin
    repeat (20) @(posedge REF_CLK);
    RSTN <= 1'b1;
    t_idle;
    t_flags;
    t_activate;
    t_bridge;
    t_lamp;
    t_mirror;
    t_standby;
    report_and_stop;
  end
endmodule
